// ===== logic/gbc_top.sv
//////////////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////////////
module gbc_top
	import gbc_pkg::*;
#(
	parameter int DEB_CYC_2 = GBC_DEB_US_2 * (GBC_CLK_KHZ / 1000),
	parameter int DEB_CYC_3 = GBC_DEB_US_3 * (GBC_CLK_KHZ / 1000),
	parameter int DEB_CYC_4 = GBC_DEB_US_4 * (GBC_CLK_KHZ / 1000),
	parameter int DEB_CYC_5 = GBC_DEB_US_5 * (GBC_CLK_KHZ / 1000),
	parameter int DEB_CYC_6 = GBC_DEB_US_6 * (GBC_CLK_KHZ / 1000),
	parameter int DEB_CYC_7 = GBC_DEB_US_7 * (GBC_CLK_KHZ / 1000)
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	input wire logic [2:0] debounce_time,
	input wire logic [4:0] pin_in,
	output logic pin2_out,
	output logic pin2_oe,
	output logic pin3_out,
	output logic pin3_oe,
	output logic [4:0] pin_active,
	output logic [4:0] pin_event,
	output logic track_enable,
	output logic [1:0] reg_enabled,
	output logic [1:0] reg_voltage_second,
	output logic [1:0] reg_pulldown_on
);

	//////////////////////////////////////////////////////////////////////////
	// Returns the cycle count for a debounce setting, zero meaning none.
	function automatic logic [GBC_CNT_W-1:0] deb_limit(input logic [2:0] sel);
		logic [GBC_CNT_W-1:0] r;
		r = '0;
		unique case (sel)
			3'h1: r = GBC_CNT_W'(GBC_DEB_CYC_1);
			3'h2: r = GBC_CNT_W'(DEB_CYC_2);
			3'h3: r = GBC_CNT_W'(DEB_CYC_3);
			3'h4: r = GBC_CNT_W'(DEB_CYC_4);
			3'h5: r = GBC_CNT_W'(DEB_CYC_5);
			3'h6: r = GBC_CNT_W'(DEB_CYC_6);
			3'h7: r = GBC_CNT_W'(DEB_CYC_7);
			3'h0: r = '0;
		endcase
		return r;
	endfunction : deb_limit

	// Picks one pin bit by a two-bit select; code zero selects nothing.
	function automatic logic pick_pin(input logic [1:0] sel, input logic [3:0] pins);
		return (sel == 2'h0) ? 1'b0 : pins[sel];
	endfunction : pick_pin

	//////////////////////////////////////////////////////////////////////////
	// Stored registers.
	logic [7:0] cfg01; // Pins zero and one configuration.
	logic [7:0] cfg23; // Pins two and three configuration.
	logic [7:0] cfg4; // Pin four configuration.
	logic [7:0] ctl [2]; // Regulator A and B control.

	// Per-pin configuration fields gathered into vectors.
	logic [3:0] nib [5];
	logic [4:0] deb_on; // Debounce select or output level bits.
	logic [4:0] pol; // Active level of each pin.
	logic [4:0] is_input; // Pin is used as an ordinary input.

	assign nib[0] = cfg01[3:0];
	assign nib[1] = cfg01[7:4];
	assign nib[2] = cfg23[3:0];
	assign nib[3] = cfg23[7:4];
	assign nib[4] = cfg4[3:0];

	// Only code zero is an input on every pin; pin zero also tracks.
	generate
		for (genvar i = 0; i < 5; i++) begin : g_fields
			assign deb_on[i] = nib[i][GBC_POS_DEB];
			assign pol[i] = nib[i][GBC_POS_POL];
			assign is_input[i] = (nib[i][1:0] == GBC_FN_INPUT);
		end
	endgenerate

	//////////////////////////////////////////////////////////////////////////
	// Register decode and readback; reserved bits read as zero.
	wire hit01 = (reg_addr == GBC_OFS_PINS01);
	wire hit23 = (reg_addr == GBC_OFS_PINS23);
	wire hit4 = (reg_addr == GBC_OFS_PIN4);
	wire hita = (reg_addr == GBC_OFS_REGA);
	wire hitb = (reg_addr == GBC_OFS_REGB);
	wire [7:0] next_rdata = hit01 ? cfg01 : hit23 ? cfg23 : hit4 ? cfg4 :
		hita ? ctl[0] : hitb ? ctl[1] : 8'h00;

	// Configuration writes; reserved bits are never stored.
	always_ff @(posedge clk) begin
		if (!rstn) begin
			cfg01 <= GBC_RST_CFG;
			cfg23 <= GBC_RST_CFG;
			cfg4 <= GBC_RST_CFG;
			reg_rdata <= 8'h00;
		end else begin
			reg_rdata <= next_rdata;
			if (reg_wr && hit01) begin
				cfg01 <= reg_wdata;
			end
			if (reg_wr && hit23) begin
				cfg23 <= reg_wdata;
			end
			if (reg_wr && hit4) begin
				cfg4 <= reg_wdata & GBC_WMASK_PIN4;
			end
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Input path: two-stage synchroniser, debounce filter, edge detector.
	logic [4:0] sync_a; // First stage, read only by sync_b.
	logic [4:0] sync_b; // Second stage.
	logic [4:0] filt; // Filtered pin level.
	logic [4:0] act_d; // Previous active state.
	logic [GBC_CNT_W-1:0] cnt [5];
	wire [GBC_CNT_W-1:0] limit = deb_limit(debounce_time);
	wire [4:0] act = ~(filt ^ pol);
	wire [4:0] rise = act & ~act_d & is_input;
	wire [4:0] fall = ~act & act_d & is_input;

	// Synchronise the pins before anything looks at them.
	always_ff @(posedge clk) begin
		if (!rstn) begin
			sync_a <= GBC_RST_PINS;
			sync_b <= GBC_RST_PINS;
		end else begin
			sync_a <= pin_in;
			sync_b <= sync_a;
		end
	end

	// A level is taken once it has stood for the debounce time.
	generate
		for (genvar i = 0; i < 5; i++) begin : g_deb
			wire use_deb = deb_on[i] && (limit != '0);
			always_ff @(posedge clk) begin
				if (!rstn) begin
					filt[i] <= GBC_RST_PINS[i]; // Passive at reset polarity, so no false edge follows reset.
					cnt[i] <= '0;
				end else if (sync_b[i] == filt[i]) begin
					cnt[i] <= '0;
				end else if (!use_deb || cnt[i] >= limit - 1'b1) begin
					filt[i] <= sync_b[i];
					cnt[i] <= '0;
				end else begin
					cnt[i] <= cnt[i] + 1'b1;
				end
			end
		end
	endgenerate

	// Edge memory and event pulses, one per active-state change of an input pin.
	always_ff @(posedge clk) begin
		if (!rstn) begin
			act_d <= 5'h00;
			pin_event <= 5'h00;
			pin_active <= 5'h00;
			track_enable <= 1'b0;
		end else begin
			act_d <= act;
			pin_event <= rise | fall;
			pin_active <= act;
			track_enable <= (nib[0][1:0] == GBC_FN_TRACK) && act[0];
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Pins two and three as outputs: level bit, polarity and drive type.
	wire [1:0] out_val = {~(deb_on[3] ^ pol[3]), ~(deb_on[2] ^ pol[2])};

	// Push-pull drives both levels; open-drain only pulls low.
	always_ff @(posedge clk) begin
		if (!rstn) begin
			pin2_out <= 1'b0;
			pin2_oe <= 1'b0;
			pin3_out <= 1'b0;
			pin3_oe <= 1'b0;
		end else begin
			pin2_out <= (nib[2][1:0] == GBC_FN_PUSH_PULL) && out_val[0];
			pin2_oe <= (nib[2][1:0] == GBC_FN_PUSH_PULL) || ((nib[2][1:0] == GBC_FN_OPEN_DRAIN) && !out_val[0]);
			pin3_out <= (nib[3][1:0] == GBC_FN_PUSH_PULL) && out_val[1];
			pin3_oe <= (nib[3][1:0] == GBC_FN_PUSH_PULL) || ((nib[3][1:0] == GBC_FN_OPEN_DRAIN) && !out_val[1]);
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Regulator control: pin edges update the same bits software writes.
	generate
		for (genvar r = 0; r < 2; r++) begin : g_reg
			wire [1:0] esel = ctl[r][GBC_POS_ESEL +: 2];
			wire [1:0] vsel = ctl[r][GBC_POS_VSEL +: 2];
			// Enable pins: 01 pin zero, 10 pin one, 11 pin three.
			wire en_up = pick_pin(esel, {rise[3], rise[1], rise[0], 1'b0});
			wire en_dn = pick_pin(esel, {fall[3], fall[1], fall[0], 1'b0});
			// Voltage pins: 01 pin one, 10 pin two, 11 pin four.
			wire v_up = pick_pin(vsel, {rise[4], rise[2], rise[1], 1'b0});
			wire v_dn = pick_pin(vsel, {fall[4], fall[2], fall[1], 1'b0});
			wire wr = reg_wr && ((r == 0) ? hita : hitb);
			wire [7:0] base = wr ? (reg_wdata & GBC_WMASK_CTL) : ctl[r];
			logic [7:0] next_ctl;
			always_comb begin
				next_ctl = base;
				if (en_up) begin
					next_ctl[GBC_POS_ON] = 1'b1;
				end else if (en_dn) begin
					next_ctl[GBC_POS_ON] = 1'b0;
				end
				if (v_up) begin
					next_ctl[GBC_POS_VCHOICE] = 1'b1;
				end else if (v_dn) begin
					next_ctl[GBC_POS_VCHOICE] = 1'b0;
				end
			end
			// A pin edge in the same cycle as a write wins over the write.
			always_ff @(posedge clk) begin
				if (!rstn) begin
					ctl[r] <= GBC_RST_CTL;
				end else begin
					ctl[r] <= next_ctl;
				end
			end
			assign reg_enabled[r] = ctl[r][GBC_POS_ON];
			assign reg_voltage_second[r] = ctl[r][GBC_POS_VCHOICE];
			assign reg_pulldown_on[r] = !ctl[r][GBC_POS_ON] && !ctl[r][GBC_POS_PDOFF];
		end
	endgenerate

	//////////////////////////////////////////////////////////////////////////
	// Checks on the design's own behaviour.
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	AST_PP_DRIVES: assert property ((cfg23[1:0] == GBC_FN_PUSH_PULL) |=> pin2_oe)
		else $error("push-pull pin two not driven");
	AST_OD_NO_HIGH: assert property ((cfg23[5:4] == GBC_FN_OPEN_DRAIN) |=> !pin3_out && (pin3_oe == !$past(out_val[1])))
		else $error("open-drain pin three drove high or wrong enable");
	AST_OUT_LEVEL: assert property ((cfg23[1:0] == GBC_FN_PUSH_PULL) |=> pin2_out == $past(cfg23[3] == cfg23[2]))
		else $error("pin two output level wrong");
	AST_IN_NOT_DRIVEN: assert property ((cfg23[5:4] == GBC_FN_INPUT) |=> !pin3_oe)
		else $error("input pin three driven");
	AST_ENABLE_RISE: assert property ((ctl[0][2:1] == 2'h1) && rise[0] |=> reg_enabled[0])
		else $error("regulator A not enabled on pin edge");
	AST_ENABLE_FALL: assert property ((ctl[1][2:1] == 2'h3) && fall[3] |=> !reg_enabled[1])
		else $error("regulator B not disabled on pin edge");
	AST_VOLT_RISE: assert property ((ctl[0][6:5] == 2'h3) && rise[4] |=> reg_voltage_second[0])
		else $error("regulator A not switched to second target");
	AST_VOLT_FALL: assert property ((ctl[1][6:5] == 2'h2) && fall[2] |=> !reg_voltage_second[1])
		else $error("regulator B not switched to first target");
	AST_PULLDOWN: assert property (reg_wr && hita && !g_reg[0].en_up && !g_reg[0].en_dn |=>
		reg_pulldown_on[0] == $past(!reg_wdata[GBC_POS_ON] && !reg_wdata[GBC_POS_PDOFF]))
		else $error("pull-down connected wrongly");
	AST_RESERVED: assert property (ctl[0][7] == 1'b0 && ctl[1][7] == 1'b0 && cfg4[7:4] == 4'h0)
		else $error("reserved bits set");
	AST_DIRECT_PASS: assert property (!deb_on[1] && $changed(sync_b[1]) && sync_b[1] != filt[1] |=> filt[1] == $past(sync_b[1]))
		else $error("undebounced input not passed in one cycle");
	AST_DEB_HOLD: assert property (deb_on[0] && debounce_time != 3'h0 && $rose(sync_b[0]) |=> !filt[0] [*8])
		else $error("debounced input passed too early");
	AST_EVENT_ONE: assert property (pin_event[0] |=> !pin_event[0])
		else $error("event lasted more than one cycle");

	COV_ENABLE: cover property (rise[0] && ctl[0][2:1] == 2'h1);
	COV_VOLT: cover property (fall[4] && ctl[1][6:5] == 2'h3);
	COV_PP_OUT: cover property (pin2_oe && pin2_out);
	COV_DEB_TAKE: cover property (deb_on[1] && debounce_time != 3'h0 && $rose(filt[1]));

endmodule : gbc_top

// ===== logic/gbc_pkg.sv
package gbc_pkg;
	// Register offsets on the control port.
	localparam logic [7:0] GBC_OFS_PINS01 = 8'h58;
	localparam logic [7:0] GBC_OFS_PINS23 = 8'h59;
	localparam logic [7:0] GBC_OFS_PIN4 = 8'h5A;
	localparam logic [7:0] GBC_OFS_REGA = 8'h5D;
	localparam logic [7:0] GBC_OFS_REGB = 8'h5E;
	// Reset values of the stored registers.
	localparam logic [7:0] GBC_RST_CFG = 8'h00;
	localparam logic [7:0] GBC_RST_CTL = 8'h00;
	// Reset level of the pin synchronisers and filters; it matches the passive level of the reset polarity.
	localparam logic [4:0] GBC_RST_PINS = 5'h1F;
	// Writable bits of each register; the rest read as zero.
	localparam logic [7:0] GBC_WMASK_PIN4 = 8'h0F;
	localparam logic [7:0] GBC_WMASK_CTL = 8'h7F;
	// Field positions inside a pin nibble (low nibble pin 0/2/4, high pin 1/3).
	localparam int GBC_POS_DEB = 3;
	localparam int GBC_POS_POL = 2;
	localparam int GBC_POS_FN = 0;
	// Field positions inside a regulator control register.
	localparam int GBC_POS_VSEL = 5;
	localparam int GBC_POS_VCHOICE = 4;
	localparam int GBC_POS_PDOFF = 3;
	localparam int GBC_POS_ESEL = 1;
	localparam int GBC_POS_ON = 0;
	// Pin function codes.
	localparam logic [1:0] GBC_FN_INPUT = 2'h0;
	localparam logic [1:0] GBC_FN_TRACK = 2'h1;
	localparam logic [1:0] GBC_FN_OPEN_DRAIN = 2'h2;
	localparam logic [1:0] GBC_FN_PUSH_PULL = 2'h3;
	// Clock rate and debounce times, times in microseconds.
	localparam int GBC_CLK_KHZ = 25000;
	localparam int GBC_DEB_US_1 = 100;
	localparam int GBC_DEB_US_2 = 1000;
	localparam int GBC_DEB_US_3 = 10000;
	localparam int GBC_DEB_US_4 = 50000;
	localparam int GBC_DEB_US_5 = 250000;
	localparam int GBC_DEB_US_6 = 500000;
	localparam int GBC_DEB_US_7 = 1000000;
	// Cycles for the shortest debounce time, rounded up.
	localparam int GBC_DEB_CYC_1 = (GBC_DEB_US_1 * GBC_CLK_KHZ + 999) / 1000;
	// Width of the debounce counters.
	localparam int GBC_CNT_W = 25;
endpackage : gbc_pkg

// ===== tb/gbc_host_pins.sv
//////////////////////////////////////////////////////////////////////////////
// Host side of the pins: drives the requested levels and gives way to the block's drivers.
module gbc_host_pins (
	input wire logic [4:0] want,
	input wire logic pin2_out,
	input wire logic pin2_oe,
	input wire logic pin3_out,
	input wire logic pin3_oe,
	output logic [4:0] pin_in
);
	timeunit 1ns;
	timeprecision 1ns;
	// Levels are held between requests, so each one stands until the bench requests another.
	always_comb begin
		pin_in = want;
		// A pin that the block drives shows the block's level on the wire.
		if (pin2_oe) begin
			pin_in[2] = pin2_out;
		end
		if (pin3_oe) begin
			pin_in[3] = pin3_out;
		end
	end
endmodule : gbc_host_pins

// ===== tb/tb_top.sv
//////////////////////////////////////////////////////////////////////////////
// Bench for the pin and regulator control block.
module tb_top;
	import gbc_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct packed {logic [1:0] kind; logic [7:0] val;} gbc_note_t;
	logic clk = 1'b0, rstn = 1'b0, reg_wr = 1'b0, chk = 1'b0;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, d;
	logic [2:0] debounce_time = 3'h0;
	logic [4:0] want = 5'h16, pol = 5'h09; // Pins 0 and 3 active high, others active low.
	logic [7:0] reg_rdata;
	logic [4:0] pin_in, pin_active, pin_event;
	logic pin2_out, pin2_oe, pin3_out, pin3_oe, track_enable, lvl, oe, o;
	logic [1:0] reg_enabled, reg_voltage_second, reg_pulldown_on;
	logic [7:0] amap [6] = '{8'h58, 8'h59, 8'h5A, 8'h5D, 8'h5E, 8'h00};
	logic [7:0] wm [6] = '{8'hFF, 8'hFF, GBC_WMASK_PIN4, GBC_WMASK_CTL, GBC_WMASK_CTL, 8'h00};
	int mismatches = 0, cmp_count = 0, seed = 5248, ev_cnt = 0, ev_base = 0, p, lim;
	gbc_note_t q[$];
	always #20 clk = ~clk;
	gbc_top #(.DEB_CYC_2(20), .DEB_CYC_3(40), .DEB_CYC_4(60), .DEB_CYC_5(80), .DEB_CYC_6(100))
		DUT (.clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .debounce_time(debounce_time), .pin_in(pin_in),
		.pin2_out(pin2_out), .pin2_oe(pin2_oe), .pin3_out(pin3_out), .pin3_oe(pin3_oe),
		.pin_active(pin_active), .pin_event(pin_event), .track_enable(track_enable),
		.reg_enabled(reg_enabled), .reg_voltage_second(reg_voltage_second),
		.reg_pulldown_on(reg_pulldown_on));
	gbc_host_pins host (.want(want), .pin2_out(pin2_out), .pin2_oe(pin2_oe),
		.pin3_out(pin3_out), .pin3_oe(pin3_oe), .pin_in(pin_in));
	// Counts every event pulse the block raises.
	always @(posedge clk) ev_cnt <= ev_cnt + $countones(pin_event);
	// Packed views of the regulator outputs and of the driven pins.
	wire [7:0] reg_view = {1'b0, track_enable, reg_enabled, reg_voltage_second, reg_pulldown_on};
	wire [7:0] drive_view = {4'h0, pin3_oe, pin3_oe & pin3_out, pin2_oe, pin2_oe & pin2_out};
	// Compares one result against its expected value and counts it.
	task automatic cmp(input string nm, input logic [7:0] e, input logic [7:0] g);
		cmp_count++;
		if (g !== e) begin
			mismatches++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask : cmp
	// Monitor: takes the oldest note when the driver marks a result as due.
	always @(posedge clk) begin : mon
		gbc_note_t n;
		if (chk === 1'b1) begin
			n = q.pop_front();
			case (n.kind)
				2'h0: cmp("reg_rdata", n.val, reg_rdata);
				2'h1: cmp("regulator", n.val, reg_view);
				2'h2: cmp("pin_drive", n.val, drive_view);
				default: cmp("pin_active", n.val, {3'h0, pin_active});
			endcase
		end
	end
	// Notes an expected result and marks it due at the next rising edge.
	task automatic note(input logic [1:0] k, input logic [7:0] v);
		q.push_back('{k, v});
		chk = 1'b1;
		@(negedge clk);
		chk = 1'b0;
		@(negedge clk);
	endtask : note
	// One register write; the strobe drops and an edge passes before the next one.
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		reg_addr = a;
		reg_wdata = v;
		reg_wr = 1'b1;
		@(negedge clk);
		reg_wr = 1'b0;
		@(negedge clk);
	endtask : wr
	// Read: the data follows the address one cycle later.
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		reg_addr = a;
		@(negedge clk);
		note(2'h0, e);
	endtask : rd
	// Moves pin k to its active or passive level, then waits w cycles.
	task automatic act(input int k, input logic a, input int w);
		want[k] = a ? pol[k] : ~pol[k];
		repeat (w) @(negedge clk);
	endtask : act
	// Ends the run with the counts and the verdict.
	task automatic close_out;
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : close_out
	// Watchdog against a hang.
	initial begin
		#(40 * 20000);
		mismatches++;
		close_out;
	end
	// Main sequence.
	initial begin
		repeat (16) @(negedge clk);
		rstn = 1'b1;
		for (int i = 0; i < 6; i++) rd(amap[i], GBC_RST_CFG);
		for (int j = 0; j < 4; j++) begin
			for (int i = 0; i < 6; i++) begin
				d = $random(seed);
				wr(amap[i], d);
				rd(amap[i], d & wm[i]);
			end
		end
		// Every function, mode and polarity on both driven pins.
		for (int i = 0; i < 16; i++) begin
			d = {i[3:0], i[3:0]};
			wr(GBC_OFS_PINS23, d);
			repeat (2) @(negedge clk);
			lvl = d[3] ? d[2] : ~d[2];
			oe = (d[1:0] == 2'h3) | ((d[1:0] == 2'h2) & ~lvl);
			o = (d[1:0] == 2'h3) & lvl;
			note(2'h2, {4'h0, oe, o, oe, o});
		end
		// Second reset in mid-run, then the pin actions with a filter time set.
		rstn = 1'b0;
		repeat (2) @(negedge clk);
		rstn = 1'b1;
		debounce_time = 3'h2;
		wr(8'h58, 8'h04);
		wr(8'h59, 8'h40);
		wr(8'h5A, 8'h00);
		wr(8'h5E, 8'h08);
		repeat (8) @(negedge clk);
		ev_base = ev_cnt;
		for (int k = 1; k < 4; k++) begin
			p = (k == 1) ? 0 : (k == 2) ? 1 : 3;
			wr(8'h5D, 8'(k << 1));
			wr(8'h5E, 8'(8 | (k << 1)));
			act(p, 1'b1, 8);
			note(2'h1, 8'h30);
			note(2'h3, 8'(1 << p));
			act(p, 1'b0, 8);
			note(2'h1, 8'h01);
		end
		for (int k = 1; k < 4; k++) begin
			p = (k == 1) ? 1 : (k == 2) ? 2 : 4;
			wr(8'h5D, 8'(k << 5));
			wr(8'h5E, 8'(8 | (k << 5)));
			act(p, 1'b1, 8);
			note(2'h1, 8'h0D);
			note(2'h3, 8'(1 << p));
			act(p, 1'b0, 8);
			note(2'h1, 8'h01);
		end
		wr(8'h5D, 8'h11);
		wr(8'h5E, 8'h19);
		note(2'h1, 8'h3C);
		wr(8'h5D, 8'h00);
		wr(8'h5E, 8'h08);
		note(2'h1, 8'h01);
		// Filtered pin zero: a short glitch is dropped, a long level is taken.
		wr(8'h58, 8'h0C);
		wr(8'h5D, 8'h02);
		act(0, 1'b1, 10);
		act(0, 1'b0, 30);
		note(2'h1, 8'h01);
		act(0, 1'b1, 30);
		note(2'h1, 8'h10);
		act(0, 1'b0, 30);
		// Filter settings one to six: a level shorter than the filter is dropped, a longer one is taken.
		for (int s = 1; s < 7; s++) begin
			debounce_time = 3'(s);
			lim = (s == 1) ? GBC_DEB_CYC_1 : 20 * (s - 1);
			act(0, 1'b1, lim - 4);
			act(0, 1'b0, 30);
			note(2'h1, 8'h01);
			act(0, 1'b1, lim + 6);
			note(2'h1, 8'h10);
			act(0, 1'b0, lim + 6);
		end
		// Track function on pin zero takes the pin away from the enable select.
		wr(8'h58, 8'h05);
		act(0, 1'b1, 8);
		note(2'h1, 8'h41);
		act(0, 1'b0, 8);
		// A reserved function on pin one leaves the voltage select alone.
		wr(8'h58, 8'h14);
		wr(8'h5D, 8'h20);
		act(1, 1'b1, 8);
		note(2'h1, 8'h01);
		act(1, 1'b0, 8);
		wr(8'h58, 8'h04);
		repeat (8) @(negedge clk);
		cmp("events", 8'h1A, 8'(ev_cnt - ev_base));
		close_out;
	end
endmodule : tb_top
